//--- common/lgc_map.vh
// Register map, field layout and reset values of the line interface global control block
// ****************************************************************************
// Overview of operation
// [RULE1] The global control register drives one shared setting to all eight channels and resets to zero.
// [RULE2] With global bit 7 set, every access to the phase data window advances the phase-sample field of the waveform address register.
// [RULE3] Software sets global bit 7 before enabling any waveform generator channel if it wants auto-increment.
// [RULE4] Global bit 6 gates automatic all-ones alarm insertion into all eight receive paths on loss of signal.
// [RULE5] Software always writes zero to the reserved global bit 5.
// [RULE6] Global bit 4 selects the line code: 0 for B8ZS or HDB3, 1 for plain AMI.
// [RULE7] Global bit 3 selects the jitter FIFO depth: 0 for 32 bits, 1 for 64 bits.
// [RULE8] Global bit 2 selects the jitter corner frequency: 0 for the lower, 1 for the higher corner.
// [RULE9] Global bits 1:0 place the jitter attenuator: 00 and 10 off, 01 transmit path, 11 receive path.
// [RULE10] Bits 2:0 of the channel selector choose the channel reached by the pulse-shape data register.
// [RULE11] Pulse-shape data reads and writes reach only the channel held in the channel selector.
// [RULE12] Software writes zeros to the reserved channel selector bits 7:3.
// [RULE13] The channel selector resets to zero, which selects channel 0.
// [RULE14] Both registers read back the last value written and reads have no side effect.
// ****************************************************************************
`ifndef LGC_MAP_VH
`define LGC_MAP_VH

// Register indices; the byte address is four times the index
`define LGC_IDX_GLOBAL 8'h0F
`define LGC_IDX_CHSEL 8'h10
`define LGC_IDX_SHAPE 8'h11
`define LGC_IDX_WADDR 8'h17
`define LGC_IDX_WDATA 8'h18

// Reset values
`define LGC_RST_GLOBAL 8'h00
`define LGC_RST_CHSEL 8'h00
`define LGC_RST_SHAPE 8'h00
`define LGC_RST_WADDR 8'h00

// Global control fields
`define LGC_GLB_AUTOINC 7
`define LGC_GLB_ALARM 6
`define LGC_GLB_CODE 4
`define LGC_GLB_FIFO 3
`define LGC_GLB_CORNER 2
`define LGC_GLB_JPOS_HI 1
`define LGC_GLB_JPOS_LO 0
`define LGC_JPOS_TX 2'h1
`define LGC_JPOS_RX 2'h3

// Channel selector field
`define LGC_CHSEL_HI 2
`define LGC_CHSEL_LO 0

// Phase-sample field of the waveform address register
`define LGC_PHASE_HI 4
`define LGC_PHASE_LO 0
`define LGC_PHASE_ONE 5'h01

`endif

//--- hdl/lgc_regs.v
// APB register bank for the global line control and pulse-shape channel selection
`timescale 1ns/1ps
`default_nettype none
`include "lgc_map.vh"

module lgc_regs (
    input wire pclk,
    input wire presetn,
    input wire pclk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] loss_of_signal,
    input wire [7:0] wave_rdata,
    output reg [7:0] wave_addr,
    output reg [7:0] wave_wdata,
    output reg wave_wr_pulse,
    output reg wave_rd_pulse,
    output reg auto_increment_enable,
    output reg rx_alarm_insert_enable,
    output reg line_code_select,
    output reg jitter_fifo_deep,
    output reg jitter_corner_select,
    output reg [1:0] jitter_position_select,
    output reg jitter_in_tx,
    output reg jitter_in_rx,
    output reg [2:0] shape_channel_id,
    output reg [7:0] alarm_insert,
    output reg [63:0] shape_cfg_all
);

    // ************************************************************************
    // Address decode
    // ************************************************************************
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_GLOBAL = 3'h1;
    localparam [2:0] SEL_CHSEL = 3'h2;
    localparam [2:0] SEL_SHAPE = 3'h3;
    localparam [2:0] SEL_WADDR = 3'h4;
    localparam [2:0] SEL_WDATA = 3'h5;

    // Bus handshake states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACCESS = 2'h1;

    // Word-aligned decode; any nonzero low bits or upper bits fall out as unmapped
    function [2:0] lgc_decode;
        input [31:0] addr;
        begin
            if (addr[1:0] != 2'h0 || addr[31:10] != 22'h000000) begin
                lgc_decode = SEL_NONE;
            end else if (addr[9:2] == `LGC_IDX_GLOBAL) begin
                lgc_decode = SEL_GLOBAL;
            end else if (addr[9:2] == `LGC_IDX_CHSEL) begin
                lgc_decode = SEL_CHSEL;
            end else if (addr[9:2] == `LGC_IDX_SHAPE) begin
                lgc_decode = SEL_SHAPE;
            end else if (addr[9:2] == `LGC_IDX_WADDR) begin
                lgc_decode = SEL_WADDR;
            end else if (addr[9:2] == `LGC_IDX_WDATA) begin
                lgc_decode = SEL_WDATA;
            end else begin
                lgc_decode = SEL_NONE;
            end
        end
    endfunction

    // Advance only the phase-sample field; the channel part above it is kept
    function [7:0] lgc_phase_step;
        input [7:0] addr;
        begin
            lgc_phase_step = addr;
            lgc_phase_step[`LGC_PHASE_HI:`LGC_PHASE_LO] =
                addr[`LGC_PHASE_HI:`LGC_PHASE_LO] + `LGC_PHASE_ONE;
        end
    endfunction

    // ************************************************************************
    // Storage
    // ************************************************************************
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [2:0] sel_r;
    reg [7:0] global_line_control_r;
    reg [7:0] pulse_shape_channel_select_r;
    reg [7:0] shape_mem_r [0:7];
    reg [7:0] los_meta_r;
    reg [7:0] los_sync_r;
    reg [2:0] sel_now;
    reg [31:0] rdata_nxt;
    wire setup_phase;
    wire access_done;
    wire [2:0] chan;
    integer i;

    assign setup_phase = psel && !penable && (state_r == ST_IDLE);
    assign access_done = psel && penable && (state_r == ST_ACCESS);
    assign chan = pulse_shape_channel_select_r[`LGC_CHSEL_HI:`LGC_CHSEL_LO];

    // ************************************************************************
    // Bus state machine
    // ************************************************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (setup_phase) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (access_done || !psel) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Read data is captured at setup so the answer stands through the access edge
    always @* begin
        sel_now = lgc_decode(paddr);
        rdata_nxt = 32'h00000000;
        case (sel_now)
            SEL_GLOBAL: begin
                rdata_nxt[7:0] = global_line_control_r; // RULE14
            end
            SEL_CHSEL: begin
                rdata_nxt[7:0] = pulse_shape_channel_select_r; // RULE14
            end
            SEL_SHAPE: begin
                rdata_nxt[7:0] = shape_mem_r[chan]; // RULE11
            end
            SEL_WADDR: begin
                rdata_nxt[7:0] = wave_addr;
            end
            SEL_WDATA: begin
                rdata_nxt[7:0] = wave_rdata;
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            sel_r <= SEL_NONE;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (pclk_en) begin
            state_r <= state_nxt;
            if (setup_phase) begin
                sel_r <= sel_now;
                prdata <= pwrite ? 32'h00000000 : rdata_nxt;
                pready <= 1'b1;
                pslverr <= (sel_now == SEL_NONE);
            end else if (access_done || !psel) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // ************************************************************************
    // Control registers
    // ************************************************************************
    // Reserved bits are stored as written so read-back matches the write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_line_control_r <= `LGC_RST_GLOBAL; // RULE1
            pulse_shape_channel_select_r <= `LGC_RST_CHSEL; // RULE13
        end else if (pclk_en && access_done && pwrite) begin
            if (sel_r == SEL_GLOBAL) begin
                global_line_control_r <= pwdata[7:0]; // RULE1
            end
            if (sel_r == SEL_CHSEL) begin
                pulse_shape_channel_select_r <= pwdata[7:0]; // RULE10
            end
        end
    end

    // Per-channel pulse-shape data, only the selected slot is touched
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                shape_mem_r[i] <= `LGC_RST_SHAPE;
            end
        end else if (pclk_en && access_done && pwrite && sel_r == SEL_SHAPE) begin
            shape_mem_r[chan] <= pwdata[7:0]; // RULE11
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shape_cfg_all <= 64'h0000000000000000;
            shape_channel_id <= 3'h0;
        end else if (pclk_en) begin
            for (i = 0; i < 8; i = i + 1) begin
                shape_cfg_all[i * 8 +: 8] <= shape_mem_r[i];
            end
            shape_channel_id <= chan; // RULE10
        end
    end

    // ************************************************************************
    // Waveform generator address and data window
    // ************************************************************************
    // Increment lands on the access edge together with the write pulse, so only read data used the old address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_addr <= `LGC_RST_WADDR;
            wave_wdata <= 8'h00;
            wave_wr_pulse <= 1'b0;
            wave_rd_pulse <= 1'b0;
        end else if (pclk_en) begin
            wave_wr_pulse <= 1'b0;
            wave_rd_pulse <= 1'b0;
            if (access_done && pwrite && sel_r == SEL_WADDR) begin
                wave_addr <= pwdata[7:0];
            end else if (access_done && sel_r == SEL_WDATA) begin
                if (global_line_control_r[`LGC_GLB_AUTOINC]) begin
                    wave_addr <= lgc_phase_step(wave_addr); // RULE2
                end
            end
            if (access_done && sel_r == SEL_WDATA) begin
                wave_wr_pulse <= pwrite;
                wave_rd_pulse <= !pwrite;
                if (pwrite) begin
                    wave_wdata <= pwdata[7:0];
                end
            end
        end
    end

    // ************************************************************************
    // Global settings towards the eight channels
    // ************************************************************************
    // Loss-of-signal comes from the receivers' own timing, so it is synchronised
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_meta_r <= 8'h00;
            los_sync_r <= 8'h00;
        end else if (pclk_en) begin
            los_meta_r <= loss_of_signal;
            los_sync_r <= los_meta_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_increment_enable <= 1'b0;
            rx_alarm_insert_enable <= 1'b0;
            line_code_select <= 1'b0;
            jitter_fifo_deep <= 1'b0;
            jitter_corner_select <= 1'b0;
            jitter_position_select <= 2'h0;
            jitter_in_tx <= 1'b0;
            jitter_in_rx <= 1'b0;
            alarm_insert <= 8'h00;
        end else if (pclk_en) begin
            auto_increment_enable <= global_line_control_r[`LGC_GLB_AUTOINC]; // RULE2
            rx_alarm_insert_enable <= global_line_control_r[`LGC_GLB_ALARM]; // RULE4
            line_code_select <= global_line_control_r[`LGC_GLB_CODE]; // RULE6
            jitter_fifo_deep <= global_line_control_r[`LGC_GLB_FIFO]; // RULE7
            jitter_corner_select <= global_line_control_r[`LGC_GLB_CORNER]; // RULE8
            jitter_position_select <=
                global_line_control_r[`LGC_GLB_JPOS_HI:`LGC_GLB_JPOS_LO]; // RULE9
            // Code 10 is deliberately treated as off, like 00
            jitter_in_tx <= (global_line_control_r[`LGC_GLB_JPOS_HI:`LGC_GLB_JPOS_LO]
                == `LGC_JPOS_TX); // RULE9
            jitter_in_rx <= (global_line_control_r[`LGC_GLB_JPOS_HI:`LGC_GLB_JPOS_LO]
                == `LGC_JPOS_RX); // RULE9
            // One shared enable gates every channel alike
            alarm_insert <= los_sync_r &
                {8{global_line_control_r[`LGC_GLB_ALARM]}}; // RULE4
        end
    end

endmodule // lgc_regs
`default_nettype wire

//--- testbench/lgc_regs_chk.sv
// Concurrent checks on the ports of the line control register bank
`timescale 1ns/1ps
`default_nettype none
module lgc_regs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] loss_of_signal,
    input wire logic [7:0] wave_addr,
    input wire logic wave_wr_pulse,
    input wire logic wave_rd_pulse,
    input wire logic auto_increment_enable,
    input wire logic rx_alarm_insert_enable,
    input wire logic line_code_select,
    input wire logic jitter_fifo_deep,
    input wire logic jitter_corner_select,
    input wire logic [1:0] jitter_position_select,
    input wire logic jitter_in_tx,
    input wire logic jitter_in_rx,
    input wire logic [2:0] shape_channel_id,
    input wire logic [7:0] alarm_insert
);
    // ************************************************************
    // Bus and register properties
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && pready && pclk_en;
    wire logic [6:0] glb = {auto_increment_enable, rx_alarm_insert_enable, line_code_select,
        jitter_fifo_deep, jitter_corner_select, jitter_position_select};
    a_ready_next: assert property (psel && !penable && pclk_en |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready && pclk_en |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |->
        pslverr == !(paddr inside {32'h3C, 32'h40, 32'h44, 32'h5C, 32'h60}))
        else $error("slave error mismatch");
    // Register takes the write at the access edge, the field outputs follow one edge later
    a_global_write: assert property (acc && pwrite && paddr == 32'h3C |-> ##2
        glb == {$past(pwdata[7:6], 2), $past(pwdata[4:0], 2)}) else $error("global fields wrong");
    a_global_read: assert property (acc && !pwrite && paddr == 32'h3C |->
        prdata[31:8] == 24'h0 && {prdata[7:6], prdata[4:0]} == glb) else $error("bad readback");
    a_jitter_decode: assert property (jitter_in_tx == (jitter_position_select == 2'h1) &&
        jitter_in_rx == (jitter_position_select == 2'h3)) else $error("jitter decode wrong");
    a_sel_write: assert property (acc && pwrite && paddr == 32'h40 |-> ##2
        shape_channel_id == $past(pwdata[2:0], 2)) else $error("selector not updated");
    a_alarm_pass: assert property ((rx_alarm_insert_enable && $stable(loss_of_signal))[*4]
        |-> alarm_insert == loss_of_signal) else $error("alarm not inserted");
    a_alarm_off: assert property (!rx_alarm_insert_enable [*2] |-> alarm_insert == 8'h00)
        else $error("alarm while disabled");
    a_phase_step: assert property (wave_wr_pulse || wave_rd_pulse |-> wave_addr ==
        {$past(wave_addr[7:5]), $past(wave_addr[4:0]) + (auto_increment_enable ? 5'h01 : 5'h00)})
        else $error("phase address step wrong");
    cover property (acc && pwrite && paddr == 32'h3C);
    cover property (wave_rd_pulse && auto_increment_enable);
    cover property (pready && pslverr);
endmodule // lgc_regs_chk
bind lgc_regs lgc_regs_chk lgc_regs_chk_inst (.*);
`default_nettype wire

//--- testbench/tb_liu_global_control_regs.sv
// Self-checking testbench of the line control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_liu_global_control_regs;
    logic pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [7:0] loss_of_signal = 0, wave_rdata = 0, wave_addr, wave_wdata, alarm_insert;
    logic pready, pslverr, wave_wr_pulse, wave_rd_pulse, auto_increment_enable;
    logic rx_alarm_insert_enable, line_code_select, jitter_fifo_deep, jitter_corner_select;
    logic jitter_in_tx, jitter_in_rx;
    logic [1:0] jitter_position_select;
    logic [2:0] shape_channel_id;
    logic [63:0] shape_cfg_all, exp_cfg;
    logic [7:0] gv [0:9] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02, 8'h03, 8'h00, 8'hDF};
    int errors = 0, n_checks = 0;
    always #5 pclk = ~pclk;
    lgc_regs lgc_regs_inst (.*);
    // ************************************************************
    // Bus access and comparison
    // ************************************************************
    task chk(input string nm, input logic [63:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask
    task results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_reset;
        apb(0, 32'h3C, 0);
        chk("global after reset", 0, rd);
        apb(0, 32'h40, 0);
        chk("selector after reset", 0, rd);
    endtask
    task t_global;
        foreach (gv[i]) begin
            apb(1, 32'h3C, gv[i]);
            apb(0, 32'h3C, 0);
            chk("global readback", gv[i], rd);
            chk("global fields", {gv[i][7:6], gv[i][4:0]}, lgc_regs_inst.lgc_regs_chk_inst.glb);
            chk("jitter path", {gv[i][1:0] == 2'h1, gv[i][1:0] == 2'h3}, {jitter_in_tx, jitter_in_rx});
        end
    endtask
    task t_shape;
        exp_cfg = 0;
        for (int c = 7; c >= 0; c--) begin
            apb(1, 32'h40, c);
            apb(1, 32'h44, c * 9 + 1);
            exp_cfg[8 * c +: 8] = c * 9 + 1;
            chk("channel id", c, shape_channel_id);
        end
        for (int c = 0; c < 8; c++) begin
            apb(1, 32'h40, c);
            apb(0, 32'h44, 0);
            chk("shape data", c * 9 + 1, rd);
        end
        chk("shape bank", exp_cfg, shape_cfg_all);
    endtask
    task t_alarm;
        apb(1, 32'h3C, 8'h40);
        @(posedge pclk) loss_of_signal <= 8'h5A;
        repeat (5) @(posedge pclk);
        #1 chk("alarm on", 8'h5A, alarm_insert);
        apb(1, 32'h3C, 0);
        repeat (3) @(posedge pclk);
        #1 chk("alarm off", 0, alarm_insert);
    endtask
    task t_autoinc;
        apb(1, 32'h3C, 8'h80);
        apb(1, 32'h5C, 8'hBF);
        apb(1, 32'h60, 8'h33);
        apb(0, 32'h5C, 0);
        chk("wrapped address", 8'hA0, rd);
        chk("phase data", 8'h33, wave_wdata);
        apb(0, 32'h60, 0);
        apb(0, 32'h5C, 0);
        chk("address after read", 8'hA1, rd);
        apb(1, 32'h3C, 0);
        apb(1, 32'h60, 8'h44);
        apb(0, 32'h5C, 0);
        chk("address held", 8'hA1, rd);
    endtask
    task t_unmapped;
        apb(1, 32'h04, 32'hFF);
        chk("write error", 1, er);
        apb(0, 32'h04, 0);
        chk("read error", 1, er);
        chk("read data", 0, rd);
        apb(0, 32'h3C, 0);
        chk("global untouched", 0, rd);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_global;
        t_shape;
        t_alarm;
        t_autoinc;
        t_unmapped;
        results;
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #50us;
        errors++;
        results;
    end
endmodule // tb_liu_global_control_regs
`default_nettype wire
